// ==== common/fbi_consts.svh ====
// Geometry and encoding constants for the forward block interleaver
`ifndef FBI_CONSTS_SVH
`define FBI_CONSTS_SVH
`define IL_ROWS      9'h018
`define IL_COLS      9'h010
`define BLOCK_CELLS  9'h180
`define LAST_CELL    9'h17F
`define SYM_W        8
`define FIFO_DEPTH   16
`define FIFO_AW      4
`endif

// ==== common/fbi_pkg.sv ====
// Types shared by the forward block interleaver design
`default_nettype none
`include "fbi_consts.svh"
package fbi_pkg;
  typedef enum logic [1:0] {
    fwd_interleaver_rate_full,
    fwd_interleaver_rate_half,
    fwd_interleaver_rate_quarter,
    fwd_interleaver_rate_eighth
  } rate_t;
  typedef enum logic {
    mode_interleave,
    mode_deinterleave
  } mode_t;
  typedef struct packed {
    logic [`SYM_W-1:0] sym;
    logic              last;
  } beat_t;
endpackage : fbi_pkg
`default_nettype wire

// ==== design/fbi_fifo.sv ====
// Parameterised valid/ready FIFO standing in front of the block array
`default_nettype none
module fbi_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ff;
  logic [AW:0]      rd_ff;
  wire              full  = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
  wire              empty = (wr_ff == rd_ff);
  wire              push  = in_valid && !full;
  wire              pop   = out_valid && out_ready;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ff[AW-1:0]];

  // Storage has no reset so it maps onto plain RAM
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ff[AW-1:0]] <= in_data;
    end
  end

  // Pointers carry one wrap bit to tell full from empty
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (push) wr_ff <= wr_ff + 1'b1;
      if (pop)  rd_ff <= rd_ff + 1'b1;
    end
  end
endmodule : fbi_fifo
`default_nettype wire

// ==== design/fwd_block_interleaver.sv ====
// Forward channel block interleaver and deinterleaver with ping-pong arrays
`default_nettype none
`include "fbi_consts.svh"
module fwd_block_interleaver
  import fbi_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire mode_t             mode,
  input  wire rate_t             rate,
  input  wire logic [`SYM_W-1:0] sym_in,
  input  wire logic              sym_in_valid,
  output logic                   sym_in_ready,
  output beat_t                  sym_out,
  output logic                   sym_out_valid,
  input  wire logic              sym_out_ready,
  output logic                   busy
);
  // ---------------------------------------------------------------
  // Input FIFO
  // ---------------------------------------------------------------
  beat_t             fifo_out;
  logic              fifo_valid;
  logic              fifo_ready;
  logic              unused_last;

  // Input path is a plain symbol stream regardless of rate
  fbi_fifo #(
    .WIDTH ($bits(beat_t)),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .clock     (clock),
    .rstn      (rstn),
    .in_data   ({sym_in, 1'b0}),
    .in_valid  (sym_in_valid),
    .in_ready  (sym_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready)
  );
  assign unused_last = fifo_out.last;

  // ---------------------------------------------------------------
  // Ping-pong block arrays
  // ---------------------------------------------------------------
  // Two 384-cell banks; rate input is ignored on purpose since geometry is fixed
  logic [`SYM_W-1:0] bank [2][`BLOCK_CELLS];
  logic              wbank_ff;
  logic [8:0]        wcnt_ff;
  logic [1:0]        full_ff;
  logic              rbank_ff;
  logic [8:0]        rcnt_ff;
  logic              ovalid_ff;
  beat_t             odata_ff;
  logic [1:0]        unused_rate;
  mode_t             rmode_ff;
  assign unused_rate = rate;

  // Write side: cell index equals arrival count, i.e. column-wise fill
  wire   wr_go   = fifo_valid && !full_ff[wbank_ff];
  assign fifo_ready = !full_ff[wbank_ff];
  wire   wr_done = wr_go && (wcnt_ff == `LAST_CELL);

  // Read address: interleave reads row by row of 24x16; column-major cell
  // is col*rows+row.  Deinterleave inverts that over the 16x24 view.
  wire [8:0] rdiv_il  = 9'(rcnt_ff / `IL_COLS);
  wire [8:0] rmod_il  = 9'(rcnt_ff % `IL_COLS);
  wire [8:0] addr_il  = 9'(rmod_il * `IL_ROWS + rdiv_il);
  wire [8:0] rdiv_dl  = 9'(rcnt_ff / `IL_ROWS);
  wire [8:0] rmod_dl  = 9'(rcnt_ff % `IL_ROWS);
  wire [8:0] addr_dl  = 9'(rmod_dl * `IL_COLS + rdiv_dl);
  wire [8:0] raddr    = (rmode_ff == mode_deinterleave) ? addr_dl : addr_il;
  wire       out_free = !ovalid_ff || sym_out_ready;
  wire       rd_go    = full_ff[rbank_ff] && out_free;
  wire       rd_done  = rd_go && (rcnt_ff == `LAST_CELL);

  assign sym_out       = odata_ff;
  assign sym_out_valid = ovalid_ff;
  assign busy          = |full_ff;

  // Bank storage
  always_ff @(posedge clock) begin
    if (wr_go) begin
      bank[wbank_ff][wcnt_ff] <= fifo_out.sym;
    end
  end

  // Write counter and bank swap
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wcnt_ff  <= '0;
      wbank_ff <= 1'b0;
    end else if (wr_go) begin
      wcnt_ff  <= wr_done ? 9'h000 : wcnt_ff + 9'h001;
      wbank_ff <= wr_done ? !wbank_ff : wbank_ff;
    end
  end

  // Full flags: set on last write, cleared on last read of that bank
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      full_ff <= '0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (wr_done && wbank_ff == 1'(b)) full_ff[b] <= 1'b1;
        else if (rd_done && rbank_ff == 1'(b)) full_ff[b] <= 1'b0;
      end
    end
  end

  // Read counter; mode is held while the read bank is full so a change mid-block is safe
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rcnt_ff  <= '0;
      rbank_ff <= 1'b0;
      rmode_ff <= mode_interleave;
    end else begin
      if (!full_ff[rbank_ff]) rmode_ff <= mode;
      if (rd_go) begin
        rcnt_ff  <= rd_done ? 9'h000 : rcnt_ff + 9'h001;
        rbank_ff <= rd_done ? !rbank_ff : rbank_ff;
      end
    end
  end

  // Output register; last marks the final symbol of a block
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ovalid_ff <= 1'b0;
      odata_ff  <= '0;
    end else if (out_free) begin
      ovalid_ff <= rd_go;
      if (rd_go) begin
        odata_ff.sym  <= bank[rbank_ff][raddr];
        odata_ff.last <= rd_done;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_wcnt_range;
    @(posedge clock) disable iff (!rstn) wcnt_ff <= `LAST_CELL;
  endproperty
  a_wcnt_range: assert property (p_wcnt_range) else $error("write count past 383");

  property p_fill_swap;
    @(posedge clock) disable iff (!rstn)
      wr_done |=> (wcnt_ff == 9'h000) && full_ff[$past(wbank_ff)];
  endproperty
  a_fill_swap: assert property (p_fill_swap) else $error("block not marked full");

  property p_wr_step;
    @(posedge clock) disable iff (!rstn)
      (wr_go && !wr_done) |=> wcnt_ff == $past(wcnt_ff) + 9'h001;
  endproperty
  a_wr_step: assert property (p_wr_step) else $error("column fill skipped a cell");

  property p_busy_fill;
    @(posedge clock) disable iff (!rstn) wr_done |=> busy;
  endproperty
  a_busy_fill: assert property (p_busy_fill) else $error("busy missing after fill");

  property p_no_early_out;
    @(posedge clock) disable iff (!rstn) $rose(sym_out_valid) |-> $past(busy);
  endproperty
  a_no_early_out: assert property (p_no_early_out) else $error("read of partial block");

  // Read side must sit still until a whole block has landed in its bank
  property p_rd_hold;
    @(posedge clock) disable iff (!rstn) !full_ff[rbank_ff] |=> rcnt_ff == $past(rcnt_ff);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read count moved on empty bank");

  property p_rd_step;
    @(posedge clock) disable iff (!rstn)
      (rd_go && !rd_done) |=> rcnt_ff == $past(rcnt_ff) + 9'h001;
  endproperty
  a_rd_step: assert property (p_rd_step) else $error("row read skipped a cell");

  property p_last_tag;
    @(posedge clock) disable iff (!rstn) (rd_go && out_free) |=> sym_out.last == $past(rd_done);
  endproperty
  a_last_tag: assert property (p_last_tag) else $error("last tag wrong");

  property p_il_addr;
    @(posedge clock) disable iff (!rstn)
      (rmode_ff == mode_interleave && rcnt_ff == 9'h001) |-> raddr == `IL_ROWS;
  endproperty
  a_il_addr: assert property (p_il_addr) else $error("row read order wrong");

  property p_dl_addr;
    @(posedge clock) disable iff (!rstn)
      (rmode_ff == mode_deinterleave && rcnt_ff == 9'h001) |-> raddr == `IL_COLS;
  endproperty
  a_dl_addr: assert property (p_dl_addr) else $error("inverse order wrong");

  // Changing mode mid-block would mix two read orders inside one block
  property p_mode_hold;
    @(posedge clock) disable iff (!rstn) full_ff[rbank_ff] |=> $stable(rmode_ff);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed mid-block");

  property p_backpressure;
    @(posedge clock) disable iff (!rstn)
      full_ff[wbank_ff] |=> (wcnt_ff == $past(wcnt_ff)) && (wbank_ff == $past(wbank_ff));
  endproperty
  a_backpressure: assert property (p_backpressure) else $error("write into full bank");

  property p_out_hold;
    @(posedge clock) disable iff (!rstn)
      (sym_out_valid && !sym_out_ready) |=> sym_out_valid && $stable(sym_out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output dropped under stall");
endmodule : fwd_block_interleaver
`default_nettype wire

// ==== tb/fbi_sink_model.sv ====
// Downstream sink model that can throttle the output handshake
`default_nettype none
module fbi_sink_model (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic stall,
  output var logic  ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] cnt_ff;
  initial ready = 1'b0;
  // Pacing count; when stalled only one beat in four is accepted
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) cnt_ff <= 2'h0;
    else cnt_ff <= cnt_ff + 2'h1;
  end
  // Moved just after the edge so the block never sees it change at sampling
  always @(posedge clock) ready <= #1 (!stall || cnt_ff == 2'h3);
endmodule : fbi_sink_model
`default_nettype wire

// ==== tb/forward_block_interleaver_tb.sv ====
// Self-checking bench for the forward block interleaver
`default_nettype none
`include "fbi_consts.svh"
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin failures++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module forward_block_interleaver_tb
  import fbi_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic              clock = 1'b0;
  logic              rstn = 1'b0;
  mode_t             mode = mode_interleave;
  rate_t             rate = fwd_interleaver_rate_full;
  logic [`SYM_W-1:0] sym_in = 8'h00;
  logic              sym_in_valid = 1'b0;
  logic              stall = 1'b0;
  logic              sym_in_ready, sym_out_valid, sym_out_ready, busy;
  logic              refused_ff = 1'b0;
  logic              busy_ff = 1'b0;
  beat_t             sym_out;
  int                failures = 0;
  int                n_checks = 0;
  int                cyc = 0;

  fwd_block_interleaver uut (.clock(clock), .rstn(rstn), .mode(mode), .rate(rate),
    .sym_in(sym_in), .sym_in_valid(sym_in_valid), .sym_in_ready(sym_in_ready),
    .sym_out(sym_out), .sym_out_valid(sym_out_valid), .sym_out_ready(sym_out_ready),
    .busy(busy));
  fbi_sink_model sink (.clock(clock), .rstn(rstn), .stall(stall), .ready(sym_out_ready));

  always #20 clock = ~clock;

  // Hang guard, plus sticky flags for refusal and a full bank
  always @(posedge clock) begin
    cyc++;
    if (sym_in_ready === 1'b0) refused_ff <= 1'b1;
    if (busy === 1'b1) busy_ff <= 1'b1;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  // Input cell index of output j: column-major fill, read across the other axis
  function automatic int cell_of(mode_t m, int j);
    return (m == mode_interleave) ? (j % 16) * 24 + j / 16 : (j % 24) * 16 + j / 24;
  endfunction : cell_of

  // Source sends whole blocks; each block gets its own value offset
  task automatic run_blocks(input mode_t m, input rate_t r, input int nb);
    mode = m;
    rate = r;
    fork
      begin
        for (int k = 0; k < nb * 384; k++) begin
          sym_in = 8'(k % 384 + k / 384 * 3);
          sym_in_valid = 1'b1;
          while (sym_in_ready !== 1'b1) @(posedge clock) #1;
          @(posedge clock) #1;
        end
        sym_in_valid = 1'b0;
      end
      for (int j = 0; j < nb * 384; j++) begin
        do @(posedge clock); while (!(sym_out_valid === 1'b1 && sym_out_ready === 1'b1));
        `CHK("sym", 8'(cell_of(m, j % 384) + j / 384 * 3), sym_out.sym)
        `CHK("last", j % 384 == 383, sym_out.last)
      end
    join
    #1;
  endtask : run_blocks

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    `CHK("ready", 1'b1, sym_in_ready)
    `CHK("valid", 1'b0, sym_out_valid)
    $display("test reset done");
  endtask : t_reset

  task automatic t_rates();
    for (int i = 0; i < 4; i++) run_blocks(mode_interleave, rate_t'(i), 1);
    `CHK("busy", 1'b1, busy_ff)
    $display("test rates done");
  endtask : t_rates

  task automatic t_deinterleave();
    run_blocks(mode_deinterleave, fwd_interleaver_rate_eighth, 2);
    $display("test deinterleave done");
  endtask : t_deinterleave

  // Slow sink fills both banks and the FIFO, so input must be refused
  task automatic t_stall();
    stall = 1'b1;
    run_blocks(mode_interleave, fwd_interleaver_rate_half, 3);
    stall = 1'b0;
    `CHK("refused", 1'b1, refused_ff)
    $display("test stall done");
  endtask : t_stall

  initial begin
    repeat (16) @(posedge clock);
    #1 rstn = 1'b1;
    t_reset();
    t_rates();
    t_deinterleave();
    t_stall();
    close_out();
  end
endmodule : forward_block_interleaver_tb
`default_nettype wire
